// [rtl/sirq_pkg.sv]
// constants and state types of the shared interrupt status block
package sirq_pkg;

    // ------------------------------------------------------------
    // register and decode layout
    // ------------------------------------------------------------
    localparam int          STATUS_W   = 8;      // one bit per port
    localparam int          ADDR_W     = 10;     // io address a0..a9
    localparam int          WIN_LSB    = 4;      // window starts at a4
    localparam int          SW_W       = ADDR_W - WIN_LSB;
    localparam logic [7:0]  STATUS_RST = 8'hff;  // all ports idle
    localparam logic [7:0]  RDATA_RST  = 8'hff;
    localparam logic        PEND_LEVEL = 1'b0;   // pending reads as 0
    localparam logic        SPEED_HS_LEVEL = 1'b0; // switch on = high

    // ------------------------------------------------------------
    // baud reference timing
    // ------------------------------------------------------------
    localparam int NORMAL_MULT = 1;
    localparam int HIGH_MULT   = 8;
    localparam int CLK_HZ      = 125_000_000;
    localparam int UART_REF_HZ = 1_843_200;
    // longest spacing that still reaches the rate: round down
    localparam int HS_TICK_CYC = CLK_HZ / (UART_REF_HZ * HIGH_MULT);
    localparam int NS_TICK_CYC = HS_TICK_CYC * HIGH_MULT / NORMAL_MULT;
    localparam int TICK_CNT_W  = $clog2(NS_TICK_CYC);

    // all registered state of the top module except the assertion helpers
    typedef struct packed {
        logic [STATUS_W-1:0]   status;
        logic                  irq;
        logic [STATUS_W-1:0]   rdata;
        logic                  oe_n;
        logic                  hs;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic                  tick;
    } sirq_state_t;

endpackage

// [rtl/sirq_sync.sv]
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module sirq_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '1
) (
    // clock and reset
    input  wire logic  mclk_i,
    input  wire logic  sys_rst_i,
    // pin levels in, clean levels out
    sirq_sync_if.sink  port_if
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] clean;
    } sirq_sync_state_t;

    sirq_sync_state_t s_q;
    sirq_sync_state_t s_d;

    // refused at elaboration: a zero-width group has nothing to carry
    if (W < 1)
    begin
        $error("sirq_sync: width must be at least one");
    end

    // first stage feeds only the second stage
    always_comb
    begin
        s_d.meta  = port_if.raw;
        s_d.clean = s_q.meta;
    end

    // constants only under reset
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= {RST, RST};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign port_if.sync = s_q.clean;
endmodule
`default_nettype wire

// [rtl/sirq_sync_if.sv]
// carrier between the top module and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface sirq_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport sink (input raw, output sync);
    modport src  (output raw, input sync);
endinterface
`default_nettype wire

// [rtl/sirq_top.sv]
// shared interrupt status register, window decode and speed reference
`timescale 1ns/1ps
`default_nettype none
module sirq_top
    import sirq_pkg::*;
#(
    parameter int NPORTS = sirq_pkg::STATUS_W
) (
    // clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          sys_rst_i,
    // per-port receive interrupt requests, active high, same clock
    input  wire logic [NPORTS-1:0]             irq_req_i,
    // io bus pins
    input  wire logic [sirq_pkg::ADDR_W-1:0]   io_addr_i,
    input  wire logic                          io_aen_i,
    input  wire logic                          io_rd_n_i,
    output logic      [sirq_pkg::STATUS_W-1:0] data_o,
    output logic                               data_oe_n_o,
    // configuration switches, 1 = off
    input  wire logic [sirq_pkg::SW_W-1:0]     irq_status_addr_switch_i,
    input  wire logic                          card_config_speed_sw_i,
    // shared interrupt line and baud reference to the port engines
    output logic                               shared_irq_o,
    output logic                               high_speed_o,
    output logic                               baud_tick_o
);
    import sirq_pkg::*;

    // ------------------------------------------------------------
    // checks and pin synchronisation
    // ------------------------------------------------------------
    localparam int SYNC_W = ADDR_W + 2 + SW_W + 1;

    // refused at elaboration: the status byte has only eight lanes
    if (NPORTS < 1 || NPORTS > STATUS_W)
    begin
        $error("sirq_top: NPORTS must be 1 to 8");
    end

    sirq_sync_if #(.W(SYNC_W)) pin_if ();

    logic [ADDR_W-1:0] addr_s;
    logic              aen_s;
    logic              rd_n_s;
    logic [SW_W-1:0]   base_sw_s;
    logic              speed_sw_s;

    // every bus pin and switch is asynchronous to mclk, so all pass two flops; irq_req_i is on the same clock and does not
    assign pin_if.raw = {io_addr_i, io_aen_i, io_rd_n_i,
                         irq_status_addr_switch_i, card_config_speed_sw_i};
    assign {addr_s, aen_s, rd_n_s, base_sw_s, speed_sw_s} = pin_if.sync;

    sirq_sync #(
        .W   (SYNC_W),
        .RST ({SYNC_W{1'b1}})
    ) u_pin_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .port_if   (pin_if)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    sirq_state_t           s_q;
    sirq_state_t           s_d;
    logic [STATUS_W-1:0]   req_w;
    logic                  hit;
    logic [TICK_CNT_W-1:0] reload;

    // unused upper lanes read as idle
    always_comb
    begin
        req_w = '0;
        req_w[NPORTS-1:0] = irq_req_i;
    end

    // window decode
    // low four address bits are don't-care, so all 16 bytes answer
    // switch to address bit
    // off reads as 1, matching the address bit 1 directly
    assign hit = !aen_s && !rd_n_s
              && (addr_s[ADDR_W-1:WIN_LSB] == base_sw_s);

    // period per mode
    // taken from the synced switch, not s_d, to keep the loop open
    assign reload = (speed_sw_s == SPEED_HS_LEVEL)
                  ? TICK_CNT_W'(HS_TICK_CYC - 1)
                  : TICK_CNT_W'(NS_TICK_CYC - 1);

    always_comb
    begin
        s_d = s_q;
        // live sample
        // status follows requests each cycle; reading never alters it
        s_d.status = PEND_LEVEL ? req_w : ~req_w;
        s_d.irq = |req_w;
        // base steps
        // read data present only while the decoded read lasts
        s_d.oe_n  = !hit;
        s_d.rdata = hit ? s_q.status : RDATA_RST;
        s_d.hs = (speed_sw_s == SPEED_HS_LEVEL);
        // eightfold reference
        // mode change restarts the period, avoiding a short tick
        s_d.tick = 1'b0;
        if (s_d.hs != s_q.hs)
        begin
            s_d.tick_cnt = reload;
        end
        else if (s_q.tick_cnt == '0)
        begin
            s_d.tick     = 1'b1;
            s_d.tick_cnt = reload;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            s_q.status   <= STATUS_RST;
            s_q.irq      <= 1'b0;
            s_q.rdata    <= RDATA_RST;
            s_q.oe_n     <= 1'b1;
            s_q.hs       <= 1'b0;
            s_q.tick_cnt <= TICK_CNT_W'(NS_TICK_CYC - 1);
            s_q.tick     <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign data_o       = s_q.rdata;
    assign data_oe_n_o  = s_q.oe_n;
    assign shared_irq_o = s_q.irq;
    assign high_speed_o = s_q.hs;
    assign baud_tick_o  = s_q.tick;

    // ------------------------------------------------------------
    // assertions and their helpers
    // ------------------------------------------------------------
    localparam int HS_GAP = HS_TICK_CYC;
    localparam int NS_GAP = NS_TICK_CYC;

    logic [1:0] warm_q;
    logic [7:0] gap_q;
    logic       gap_ok_q;
    logic       hs_prev_q;

    // cycles since reset, and spacing since last tick in one mode
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            warm_q    <= 2'h0;
            gap_q     <= 8'h00;
            gap_ok_q  <= 1'b0;
            hs_prev_q <= 1'b0;
        end
        else
        begin
            hs_prev_q <= s_q.hs;
            if (warm_q != 2'h3)
                warm_q <= warm_q + 2'h1;
            if (s_q.hs != hs_prev_q)
            begin
                gap_ok_q <= 1'b0;
                gap_q    <= 8'h01;
            end
            else if (s_q.tick)
            begin
                gap_ok_q <= 1'b1;
                gap_q    <= 8'h01;
            end
            else if (gap_q != 8'hff)
                gap_q <= gap_q + 8'h01;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    a_status_polarity: assert property (
        warm_q == 2'h3 |-> s_q.status == ~$past(req_w))
        else $error("status bit does not show inverted request");

    a_read_data: assert property (
        warm_q == 2'h3 && !data_oe_n_o |-> data_o == ~$past(req_w, 2))
        else $error("read data is not the port status");

    a_irq_raise: assert property (
        |irq_req_i |=> shared_irq_o)
        else $error("shared interrupt missed a port request");

    a_irq_drop: assert property (
        !(|irq_req_i) |=> !shared_irq_o)
        else $error("shared interrupt stuck without request");

    a_window_hit: assert property (
        hit |=> !data_oe_n_o ##0 data_o == $past(s_q.status))
        else $error("decoded read was not answered");

    a_window_miss: assert property (
        !hit |=> data_oe_n_o && data_o == RDATA_RST)
        else $error("bus driven outside decoded read");

    a_base_bits: assert property (
        !data_oe_n_o |-> $past(addr_s[ADDR_W-1:WIN_LSB]) == $past(base_sw_s)
                         && !$past(aen_s) && !$past(rd_n_s))
        else $error("answer given for address outside the window");

    a_no_side_effect: assert property (
        warm_q == 2'h3 && hit && $stable(req_w) |=> $stable(s_q.status))
        else $error("status changed by a read");

    a_speed_select: assert property (
        speed_sw_s == SPEED_HS_LEVEL |=> high_speed_o)
        else $error("speed switch on did not select high speed");

    a_tick_spacing: assert property (
        baud_tick_o && gap_ok_q && high_speed_o == hs_prev_q
        |-> gap_q == (high_speed_o ? 8'(HS_GAP) : 8'(NS_GAP)))
        else $error("baud tick spacing wrong for speed mode");

    a_hs_period: assert property (
        baud_tick_o && high_speed_o ##1 high_speed_o [*8]
        |-> baud_tick_o)
        else $error("high speed tick period not kept");
endmodule
`default_nettype wire

// [testbench/sirq_host.sv]
// host processor model reading the status window over the io pins
`timescale 1ns/1ps
`default_nettype none
module sirq_host
    import sirq_pkg::*;
(
    // clock
    input  wire logic                    mclk_i,
    // read data from the card
    input  wire logic [sirq_pkg::STATUS_W-1:0] data_i,
    input  wire logic                    oe_n_i,
    // io bus pins toward the card
    output logic [sirq_pkg::ADDR_W-1:0]  io_addr_o,
    output logic                         io_aen_o,
    output logic                         io_rd_n_o
);
    // idle bus at time zero
    initial
    begin
        io_addr_o = '1;
        io_aen_o  = 1'b0;
        io_rd_n_o = 1'b1;
    end

    // one byte read: strobe held 4 cycles, sync plus register latency
    task automatic rd(input logic [ADDR_W-1:0] a, input logic aen,
                      output logic [7:0] d, output logic oe);
        @(negedge mclk_i);
        io_addr_o = a;
        io_aen_o  = aen;
        io_rd_n_o = 1'b0;
        repeat (4) @(negedge mclk_i);
        d  = data_i;
        oe = oe_n_i;
        // released address has no pull-ups: show the inverse
        io_rd_n_o = 1'b1;
        io_addr_o = ~a;
        io_aen_o  = 1'b0;
        repeat (4) @(negedge mclk_i);
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the shared interrupt status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sirq_pkg::*;
    typedef struct packed {
        logic [7:0] irq;
        logic [5:0] sw;
        logic [9:0] addr;
        logic       aen;
    } sirq_row_t;
    logic       mclk_i;
    logic       sys_rst_i = 1'b1;
    logic [7:0] irq_req = 8'h00;
    logic [5:0] addr_sw = 6'h28;
    logic       speed_sw = 1'b1;
    logic [9:0] io_addr;
    logic       io_aen, io_rd_n, oe_n, irq_o, hs, tick, o, hit;
    logic [7:0] data, d;
    int         n_mismatch = 0, check_count = 0, cyc = 0, gap;
    // window reads: in window, far edge, both ends of range, refusals
    sirq_row_t  rows [8] = '{
        '{8'h01, 6'h28, 10'h280, 1'b0}, '{8'h80, 6'h28, 10'h28f, 1'b0},
        '{8'ha5, 6'h3f, 10'h3f7, 1'b0}, '{8'h00, 6'h00, 10'h00a, 1'b0},
        '{8'hff, 6'h01, 10'h01f, 1'b0}, '{8'h3c, 6'h28, 10'h290, 1'b0},
        '{8'h3c, 6'h28, 10'h280, 1'b1}, '{8'h3c, 6'h20, 10'h280, 1'b0}};

    sirq_top sirq_top_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .irq_req_i(irq_req),
        .io_addr_i(io_addr), .io_aen_i(io_aen), .io_rd_n_i(io_rd_n),
        .data_o(data), .data_oe_n_o(oe_n),
        .irq_status_addr_switch_i(addr_sw),
        .card_config_speed_sw_i(speed_sw), .shared_irq_o(irq_o),
        .high_speed_o(hs), .baud_tick_o(tick));
    sirq_host sirq_host_i (
        .mclk_i(mclk_i), .data_i(data), .oe_n_i(oe_n),
        .io_addr_o(io_addr), .io_aen_o(io_aen), .io_rd_n_o(io_rd_n));

    // 125 MHz clock
    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // hang guard, well above the few hundred cycles needed
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // cycles between two baud ticks
    task automatic tick_gap();
        while (tick !== 1'b1) @(negedge mclk_i);
        @(negedge mclk_i);
        gap = 1;
        while (tick !== 1'b1)
        begin
            @(negedge mclk_i);
            gap++;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(negedge mclk_i);
        chk({data[7:1], oe_n}, 8'hff);
        chk({5'h0, irq_o, hs, tick}, 8'h00);
        sys_rst_i = 1'b0;
        $display("test reset done");
        foreach (rows[i])
        begin
            irq_req = rows[i].irq;
            addr_sw = rows[i].sw;
            hit = !rows[i].aen && rows[i].addr[9:4] == rows[i].sw;
            repeat (3) @(negedge mclk_i);
            chk({7'h0, irq_o}, {7'h0, |rows[i].irq});
            // second read shows reading leaves the status alone
            repeat (2)
            begin
                sirq_host_i.rd(rows[i].addr, rows[i].aen, d, o);
                chk(d, hit ? ~rows[i].irq : 8'hff);
                chk({7'h0, o}, {7'h0, !hit});
            end
        end
        $display("test window done");
        // request seen one cycle later, then withdrawn
        irq_req = 8'h00;
        repeat (2) @(negedge mclk_i);
        irq_req = 8'h04;
        @(negedge mclk_i);
        chk({7'h0, irq_o}, 8'h01);
        irq_req = 8'h00;
        @(negedge mclk_i);
        chk({7'h0, irq_o}, 8'h00);
        // reset in mid-run with every port pending
        irq_req = 8'hff;
        sys_rst_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        chk({irq_o, oe_n, data[5:0]}, 8'h7f);
        sys_rst_i = 1'b0;
        irq_req = 8'h00;
        $display("test irq done");
        tick_gap();
        chk({7'h0, hs}, 8'h00);
        chk(gap[7:0], 8'd64);
        speed_sw = 1'b0;
        repeat (4) @(negedge mclk_i);
        chk({7'h0, hs}, 8'h01);
        tick_gap();
        chk(gap[7:0], 8'd8);
        $display("test speed done");
        results();
    end
endmodule
`default_nettype wire
